//--- gpio_block.sv
// How it works
// RULE1: thirty-five pins in three pin modules of 16, 16 and 3 pins
// RULE2: per-pin function select hands a pin to a peripheral or to gpio
// RULE3: function select resets to gpio for every pin
// RULE4: output drivers and input buffers stay off after reset
// RULE5: direction register picks input or output per pin
// RULE6: modify registers touch only pins written with one
// RULE7: set register drives written-one pins high
// RULE8: clear register drives written-one pins low
// RULE9: toggle register inverts written-one pins
// RULE10: data register loads all pin values at once
// RULE11: sense register returns each pin's sensed level
// RULE12: mask set register enables interrupts for written-one pins
// RULE13: mask clear register disables interrupts for written-one pins
// RULE14: enabled input pins raise interrupts on their sensitivity condition
// RULE15: software change of an output pin value raises its interrupt
// RULE16: edge register picks level or edge sensitivity per pin
// RULE17: both register picks rising only or both edges
// RULE18: pin inputs pass two synchroniser flops before use
// RULE19: edge events stay latched until software writes one to clear
`timescale 1ns/100ps
`default_nettype none
`include "gpio_block_defs.svh"

module gpio_block
    import gpio_block_pkg::*;
#(
    parameter int W0 = 16,
    parameter int W1 = 16,
    parameter int W2 = 3,
    parameter int NPIN = W0 + W1 + W2 // RULE1
)
(
    // clock and reset
    input  wire logic            clk,
    input  wire logic            nrst,
    // axi4-lite write address
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [7:0]      s_axi_awaddr,
    input  wire logic [2:0]      s_axi_awprot,
    // axi4-lite write data
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    // axi4-lite write response
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    output logic [1:0]           s_axi_bresp,
    // axi4-lite read address
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    input  wire logic [7:0]      s_axi_araddr,
    input  wire logic [2:0]      s_axi_arprot,
    // axi4-lite read data
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    // pins
    input  wire logic [NPIN-1:0] pin_in,
    output logic [NPIN-1:0]      pin_out,
    output logic [NPIN-1:0]      pin_oe,
    // peripheral side of the multiplexer
    input  wire logic [NPIN-1:0] periph_out,
    input  wire logic [NPIN-1:0] periph_oe,
    output logic [NPIN-1:0]      periph_in,
    // interrupt
    output logic                 irq
);

    function automatic int mod_lo(input int m);
        mod_lo = (m == 0) ? 0 : (m == 1) ? W0 : W0 + W1;
    endfunction

    function automatic int mod_w(input int m);
        mod_w = (m == 0) ? W0 : (m == 1) ? W1 : W2;
    endfunction

    // spread a module-local word onto the flat pin vector
    function automatic logic [NPIN-1:0] place(input logic [31:0] v,
                                              input int m);
        logic [NPIN-1:0] r;
        r = '0;
        for (int i = 0; i < NPIN; i++)
        begin
            if (i >= mod_lo(m) && i < mod_lo(m) + mod_w(m))
                r[i] = v[i - mod_lo(m)];
        end
        return r;
    endfunction

    // gather a module's pins back into a word, upper bits zero
    function automatic logic [31:0] pick(input logic [NPIN-1:0] v,
                                         input int m);
        logic [31:0] r;
        r = '0;
        for (int j = 0; j < 32; j++)
        begin
            if (j < mod_w(m))
                r[j] = v[mod_lo(m) + j];
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        if (a[1:0] != 2'b00)
            mapped = 1'b0;
        else if (a[7:6] >= 2'(`MOD_COUNT))
            mapped = 1'b0;
        else if (a[5:0] > `OFS_FSEL)
            mapped = 1'b0;
        else
            mapped = 1'b1;
    endfunction

    // pin state
    logic [NPIN-1:0] data_q, data_d;
    logic [NPIN-1:0] dir_q, dir_d;
    logic [NPIN-1:0] mask_q, mask_d;
    logic [NPIN-1:0] edge_q, edge_d;
    logic [NPIN-1:0] both_q, both_d;
    logic [NPIN-1:0] inen_q, inen_d;
    logic [NPIN-1:0] fsel_q, fsel_d;
    logic [NPIN-1:0] event_q, event_d;
    logic [NPIN-1:0] sync1_q, sync2_q, prev_q;
    logic [NPIN-1:0] sense, ev_in, ev_out, ev_clr;

    // bus state
    logic            aw_have_q, w_have_q;
    logic [7:0]      awaddr_q;
    logic [31:0]     wdata_q;
    logic [3:0]      wstrb_q;
    logic            aw_have_d, w_have_d, wr_fire, bvalid_d, rvalid_d;
    logic            ar_take;
    logic [31:0]     bmask, wd32;
    logic [NPIN-1:0] wd, wm;
    int              wmod;
    reg_ofs_t        wofs;

    assign wr_fire = aw_have_q & w_have_q;
    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign aw_have_d = aw_have_q ? ~wr_fire
                                 : (s_axi_awvalid & s_axi_awready);
    assign w_have_d = w_have_q ? ~wr_fire
                               : (s_axi_wvalid & s_axi_wready);
    assign bvalid_d = wr_fire | (s_axi_bvalid & ~s_axi_bready);
    assign rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);

    // write decode: unstrobed bytes neither store nor modify
    always_comb
    begin
        for (int b = 0; b < 4; b++)
            bmask[b*8 +: 8] = {8{wstrb_q[b]}};
        wd32 = wdata_q & bmask;
        wmod = int'(awaddr_q[7:6]);
        wofs = awaddr_q[5:0];
        wd = '0;
        wm = '0;
        if (wr_fire && mapped(awaddr_q))
        begin
            wd = place(wd32, wmod);
            wm = place(bmask, wmod);
        end
    end

    always_comb
    begin
        data_d = data_q;
        mask_d = mask_q;
        dir_d  = dir_q;
        edge_d = edge_q;
        both_d = both_q;
        inen_d = inen_q;
        fsel_d = fsel_q;
        ev_clr = '0;
        if (wofs == `OFS_DATA)
            data_d = (data_q & ~wm) | wd; // RULE10
        else if (wofs == `OFS_CLR)
            data_d = data_q & ~wd; // RULE8 RULE6
        else if (wofs == `OFS_SET)
            data_d = data_q | wd; // RULE7 RULE6
        else if (wofs == `OFS_TGL)
            data_d = data_q ^ wd; // RULE9 RULE6
        else if (wofs == `OFS_MASK)
            mask_d = (mask_q & ~wm) | wd;
        else if (wofs == `OFS_MASK_CLR)
            mask_d = mask_q & ~wd; // RULE13
        else if (wofs == `OFS_MASK_SET)
            mask_d = mask_q | wd; // RULE12
        else if (wofs == `OFS_DIR)
            dir_d = (dir_q & ~wm) | wd; // RULE5
        else if (wofs == `OFS_EVENT)
            ev_clr = wd; // RULE19
        else if (wofs == `OFS_EDGE)
            edge_d = (edge_q & ~wm) | wd; // RULE16
        else if (wofs == `OFS_BOTH)
            both_d = (both_q & ~wm) | wd; // RULE17
        else if (wofs == `OFS_INEN)
            inen_d = (inen_q & ~wm) | wd;
        else if (wofs == `OFS_FSEL)
            fsel_d = (fsel_q & ~wm) | wd; // RULE2
    end

    // disabled input buffer senses low
    assign sense = sync2_q & inen_q; // RULE4 RULE11

    // event sources; level pins re-assert while the level holds
    always_comb
    begin
        for (int i = 0; i < NPIN; i++)
        begin
            if (dir_q[i] || fsel_q[i])
                ev_in[i] = 1'b0;
            else if (edge_q[i])
                ev_in[i] = (sense[i] & ~prev_q[i])
                         | (both_q[i] & ~sense[i] & prev_q[i]); // RULE17
            else
                ev_in[i] = sense[i]; // RULE16
        end
    end

    // lets software raise an interrupt on an output pin
    assign ev_out = (data_d ^ data_q) & dir_q & ~fsel_q; // RULE15

    // a new event wins over a clear in the same cycle
    assign event_d = (event_q & ~ev_clr) | ev_in | ev_out; // RULE14 RULE19

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end
        else
        begin
            sync1_q <= pin_in; // RULE18
            sync2_q <= sync1_q; // RULE18
            prev_q  <= sense;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            data_q  <= '0;
            mask_q  <= '0;
            dir_q   <= '0; // RULE4
            edge_q  <= '0;
            both_q  <= '0;
            inen_q  <= '0; // RULE4
            fsel_q  <= '0; // RULE3
            event_q <= '0;
        end
        else
        begin
            data_q  <= data_d;
            mask_q  <= mask_d;
            dir_q   <= dir_d;
            edge_q  <= edge_d;
            both_q  <= both_d;
            inen_q  <= inen_d;
            fsel_q  <= fsel_d;
            event_q <= event_d;
        end
    end

    // pin and peripheral outputs, registered through the multiplexer
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pin_out   <= '0;
            pin_oe    <= '0; // RULE4
            periph_in <= '0;
            irq       <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < NPIN; i++)
            begin
                pin_out[i] <= fsel_q[i] ? periph_out[i] : data_q[i]; // RULE2
                pin_oe[i]  <= fsel_q[i] ? periph_oe[i] : dir_q[i]; // RULE5
            end
            periph_in <= sync2_q & fsel_q;
            irq       <= |(event_q & mask_q); // RULE14
        end
    end

    // write channels
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            awaddr_q      <= '0;
            wdata_q       <= '0;
            wstrb_q       <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end
        else
        begin
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            if (s_axi_awvalid && s_axi_awready)
                awaddr_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            // no new address until the response is taken
            s_axi_awready <= ~aw_have_d & ~bvalid_d;
            s_axi_wready  <= ~w_have_d & ~bvalid_d;
            s_axi_bvalid  <= bvalid_d;
            if (wr_fire)
                s_axi_bresp <= mapped(awaddr_q) ? `RESP_OKAY
                                                : `RESP_SLVERR;
        end
    end

    // read channels
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~rvalid_d;
            s_axi_rvalid  <= rvalid_d;
            if (ar_take)
            begin
                s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY
                                                    : `RESP_SLVERR;
                s_axi_rdata <= '0;
                if (mapped(s_axi_araddr))
                begin
                    if (s_axi_araddr[5:0] <= `OFS_TGL)
                        s_axi_rdata <= pick(data_q,
                                            int'(s_axi_araddr[7:6]));
                    else if (s_axi_araddr[5:0] <= `OFS_MASK_SET)
                        s_axi_rdata <= pick(mask_q,
                                            int'(s_axi_araddr[7:6]));
                    else if (s_axi_araddr[5:0] == `OFS_DIR)
                        s_axi_rdata <= pick(dir_q,
                                            int'(s_axi_araddr[7:6]));
                    else if (s_axi_araddr[5:0] == `OFS_SENSE)
                        s_axi_rdata <= pick(sense,
                                            int'(s_axi_araddr[7:6])); // RULE11
                    else if (s_axi_araddr[5:0] == `OFS_EVENT)
                        s_axi_rdata <= pick(event_q,
                                            int'(s_axi_araddr[7:6]));
                    else if (s_axi_araddr[5:0] == `OFS_EDGE)
                        s_axi_rdata <= pick(edge_q,
                                            int'(s_axi_araddr[7:6]));
                    else if (s_axi_araddr[5:0] == `OFS_BOTH)
                        s_axi_rdata <= pick(both_q,
                                            int'(s_axi_araddr[7:6]));
                    else if (s_axi_araddr[5:0] == `OFS_INEN)
                        s_axi_rdata <= pick(inen_q,
                                            int'(s_axi_araddr[7:6]));
                    else
                        s_axi_rdata <= pick(fsel_q,
                                            int'(s_axi_araddr[7:6]));
                end
            end
        end
    end

endmodule
`default_nettype wire

//--- gpio_block_defs.svh
`ifndef GPIO_BLOCK_DEFS_SVH
`define GPIO_BLOCK_DEFS_SVH

// byte offsets inside one pin module's window
`define OFS_DATA     6'h00
`define OFS_CLR      6'h04
`define OFS_SET      6'h08
`define OFS_TGL      6'h0c
`define OFS_MASK     6'h10
`define OFS_MASK_CLR 6'h14
`define OFS_MASK_SET 6'h18
`define OFS_DIR      6'h1c
`define OFS_SENSE    6'h20
`define OFS_EVENT    6'h24
`define OFS_EDGE     6'h28
`define OFS_BOTH     6'h2c
`define OFS_INEN     6'h30
`define OFS_FSEL     6'h34

// module window: addr[7:6] picks the pin module, 3 is unmapped
`define MOD_SHIFT    6
`define MOD_COUNT    3

`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10

`endif

//--- gpio_block_pkg.sv
`default_nettype none
package gpio_block_pkg;
    typedef logic [1:0] axi_resp_t;
    typedef logic [1:0] pin_module_t;
    typedef logic [5:0] reg_ofs_t;
endpackage
`default_nettype wire

//--- gpio_block_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpio_block_defs.svh"
module gpio_block_asserts
    import gpio_block_pkg::*;
#(
    parameter int NPIN = 35
)
(
    // clock and reset
    input wire logic            clk,
    input wire logic            nrst,
    // write side
    input wire logic            s_axi_awvalid,
    input wire logic            s_axi_awready,
    input wire logic            s_axi_wvalid,
    input wire logic            s_axi_wready,
    input wire logic            s_axi_bvalid,
    input wire logic            s_axi_bready,
    input wire logic [1:0]      s_axi_bresp,
    // read side
    input wire logic            s_axi_arvalid,
    input wire logic            s_axi_arready,
    input wire logic            s_axi_rvalid,
    input wire logic            s_axi_rready,
    input wire logic [31:0]     s_axi_rdata,
    input wire logic [1:0]      s_axi_rresp,
    // pins and interrupt
    input wire logic [NPIN-1:0] pin_oe,
    input wire logic            irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence aw_take;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence w_take;
        s_axi_wvalid && s_axi_wready;
    endsequence
    a_quiet_reset: assert property
        ($rose(nrst) |-> pin_oe == '0 && !irq)
        else $error("pins or irq active after reset");
    a_aw_hold: assert property (aw_take |=> !s_axi_awready)
        else $error("second write address taken");
    a_write_answer: assert property
        (aw_take ##0 w_take |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_answer: assert property
        (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR
        |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while pending");
endmodule
bind gpio_block gpio_block_asserts #(.NPIN(NPIN)) gpio_block_asserts_i (
    .clk           (clk),
    .nrst          (nrst),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .pin_oe        (pin_oe),
    .irq           (irq)
);
`default_nettype wire

//--- pin_world.sv
`timescale 1ns/100ps
`default_nettype none
module pin_world
#(
    parameter int NPIN = 35
)
(
    // block side
    input wire logic [NPIN-1:0]  pin_out,
    input wire logic [NPIN-1:0]  pin_oe,
    // outside drivers
    input wire logic [NPIN-1:0]  ext_lvl,
    // resolved wire
    output wire logic [NPIN-1:0] pin_in
);
    // block drive wins; otherwise the outside driver sets the wire
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire

//--- tb_gpio_block.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpio_block_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %0t: %h not %h", $time, (g), (e)); end end
module tb_gpio_block import gpio_block_pkg::*;;
    logic        clk = 1'h0, nrst = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, irq;
    axi_resp_t   s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    wire  [34:0] pin_in;
    logic [34:0] pin_out, pin_oe, periph_in;
    logic [34:0] periph_out = 35'h0, periph_oe = 35'h2, ext_lvl = 35'h0;
    int          errors = 0, checks_done = 0;
    localparam logic [7:0] M1 = 8'h40, M2 = 8'h80;

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    gpio_block gpio_block_i (
        .clk(clk), .nrst(nrst),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .periph_out(periph_out), .periph_oe(periph_oe),
        .periph_in(periph_in), .irq(irq));
    pin_world pin_world_i (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_lvl(ext_lvl), .pin_in(pin_in));

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input axi_resp_t r = `RESP_OKAY);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awvalid <= 1'h1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'h1;
        // the write response ends the wait; the watchdog ends a hung one
        while (n == 0)
        begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid)
            begin
                `CHK(s_axi_bresp, r)
                s_axi_bready <= 1'h0;
                n = 1;
            end
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input axi_resp_t r = `RESP_OKAY);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_arvalid <= 1'h1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'h1;
        while (n == 0)
        begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid)
            begin
                `CHK(s_axi_rresp, r)
                `CHK(s_axi_rdata, e)
                s_axi_rready <= 1'h0;
                n = 1;
            end
        end
    endtask

    // edge of pin 16, then irq expected after sync and event latch
    task automatic lv(input logic v, input logic e);
        ext_lvl[16] <= v;
        repeat (5) @(posedge clk);
        `CHK(irq, e)
    endtask

    task automatic clr(input logic [7:0] a, input logic e);
        wr(a + `OFS_EVENT, 32'hffff);
        repeat (2) @(posedge clk);
        `CHK(irq, e)
    endtask

    task results;
        if (errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        nrst <= 1'h1;
        ext_lvl[34:32] <= 3'h5;
        repeat (2) @(posedge clk);
        `CHK(pin_oe, 35'h0)
        rdc(`OFS_FSEL, 32'h0);
        rdc(`OFS_DIR, 32'h0);
        rdc(M2 + `OFS_SENSE, 32'h0);
        wr(`OFS_DIR, 32'hffff);
        wr(`OFS_DATA, 32'ha5a5);
        wr(`OFS_SET, 32'h000f);
        wr(`OFS_CLR, 32'h00a0);
        wr(`OFS_TGL, 32'hff00);
        rdc(`OFS_DATA, 32'h5a0f);
        repeat (2) @(posedge clk);
        `CHK(pin_out[15:0], 16'h5a0f)
        `CHK(pin_oe[15:0], 16'hffff)
        clr(8'h0, 1'h0);
        wr(`OFS_MASK_SET, 32'h1);
        wr(`OFS_TGL, 32'h1);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'h1)
        wr(`OFS_MASK_CLR, 32'h1);
        rdc(`OFS_MASK, 32'h0);
        clr(8'h0, 1'h0);
        wr(`OFS_FSEL, 32'h2);
        repeat (2) @(posedge clk);
        `CHK(pin_out[1:0], 2'h0)
        // peripheral drives pin 1 high and sees it back through the sync
        periph_out[1] <= 1'h1;
        repeat (5) @(posedge clk);
        `CHK(pin_out[1:0], 2'h2)
        `CHK(periph_in, 35'h2)
        wr(M2 + `OFS_INEN, 32'h7);
        rdc(M2 + `OFS_SENSE, 32'h5);
        wr(M1 + `OFS_INEN, 32'h1);
        wr(M1 + `OFS_EDGE, 32'h1);
        wr(M1 + `OFS_MASK_SET, 32'h3);
        wr(M1 + `OFS_MASK_CLR, 32'h2);
        rdc(M1 + `OFS_MASK, 32'h1);
        wr(M2 + `OFS_MASK, 32'h2);
        rdc(M2 + `OFS_MASK_SET, 32'h2);
        lv(1'h1, 1'h1);
        rdc(M1 + `OFS_EVENT, 32'h1);
        clr(M1, 1'h0);
        lv(1'h0, 1'h0);
        wr(M1 + `OFS_BOTH, 32'h1);
        lv(1'h1, 1'h1);
        clr(M1, 1'h0);
        lv(1'h0, 1'h1);
        clr(M1, 1'h0);
        wr(M1 + `OFS_EDGE, 32'h0);
        lv(1'h1, 1'h1);
        clr(M1, 1'h1);
        lv(1'h0, 1'h1);
        clr(M1, 1'h0);
        rdc(8'hc0, 32'h0, `RESP_SLVERR);
        wr(8'h38, 32'h1, `RESP_SLVERR);
        results();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        results();
    end
endmodule
`default_nettype wire
